// ===== rtl/port_a_steer_cfg.svh
`ifndef PORT_A_STEER_CFG_SVH
`define PORT_A_STEER_CFG_SVH

// ==========================================================
// register offsets on the plain register port
`define OFS_PIN_DATA      3'h0
`define OFS_OUTPUT_LATCH  3'h1
`define OFS_DIRECTION     3'h2
`define OFS_ANALOG_SELECT 3'h3
`define OFS_STEERING      3'h4

// ==========================================================
// implemented bits of each register
`define MASK_LATCH        6'h37
`define MASK_DIRECTION    6'h37
`define MASK_ANALOG       6'h17
`define MASK_STEERING     8'h1B

// ==========================================================
// reset values
`define RST_LATCH         6'h00
`define RST_DIRECTION     6'h3F
`define RST_ANALOG        6'h17
`define RST_STEERING      8'h00

// ==========================================================
// field positions
`define POS_INPUT_ONLY    3
`define POS_SS_STEER      4
`define POS_TG_STEER      3
`define POS_LC_STEER      1
`define POS_OSC_STEER     0

`endif

// ===== rtl/port_a_steer_pkg.sv
package port_a_steer_pkg;

  // one peripheral output request for a pin
  typedef struct packed {
    logic en;
    logic oe;
    logic val;
  } fn_type;

  // every peripheral output that may claim a pin
  typedef struct packed {
    fn_type prog_data;
    fn_type conv_one;
    fn_type conv_two;
    fn_type logic_cell;
    fn_type comparator;
    fn_type pulse_width;
    fn_type clock_out;
    fn_type sosc_drive;
    fn_type sosc_input;
    fn_type numeric_osc;
  } periph_type;

  // register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_type;

  // steered pins of port c: c1, c5, c6 from bit 0 upward
  typedef struct packed {
    logic [2:0] ovr;
    logic [2:0] out;
    logic [2:0] oe;
  } port_c_type;

  // whole module state
  typedef struct packed {
    logic [5:0] latch;
    logic [5:0] dir;
    logic [5:0] ansel;
    logic [7:0] steer;
    logic [7:0] rdata;
    logic [5:0] pin_out;
    logic [5:0] pin_oe;
    logic [5:0] dig;
    port_c_type pc;
    logic       slave_sel;
    logic       timer_gate;
  } state_type;

endpackage

// ===== rtl/port_a_with_pin_steering.sv
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "port_a_steer_cfg.svh"
module port_a_with_pin_steering (
  input  wire logic                         clk_i,
  input  wire logic                         reset_i,
  input  wire port_a_steer_pkg::bus_type    bus_i,
  output logic      [7:0]                   rdata_o,
  input  wire logic [5:0]                   pin_a_in_i,
  output logic      [5:0]                   pin_a_out_o,
  output logic      [5:0]                   pin_a_oe_o,
  output logic      [5:0]                   pin_a_dig_o,
  input  wire logic [2:0]                   pin_c_in_i,
  output port_a_steer_pkg::port_c_type      pin_c_o,
  input  wire port_a_steer_pkg::periph_type periph_i,
  output logic                              slave_select_o,
  output logic                              timer_gate_o
);

  // ==========================================================
  // state and reset image
  port_a_steer_pkg::state_type st;
  port_a_steer_pkg::state_type next_st;

  localparam port_a_steer_pkg::state_type RESET_STATE = '{
    latch:      `RST_LATCH,
    dir:        `RST_DIRECTION,
    ansel:      `RST_ANALOG,
    steer:      `RST_STEERING,
    rdata:      8'h00,
    pin_out:    6'h00,
    pin_oe:     6'h00,
    dig:        6'h00,
    pc:         '0,
    slave_sel:  1'b0,
    timer_gate: 1'b0
  };

  // ==========================================================
  // priority helper: the higher request wins when enabled
  function automatic port_a_steer_pkg::fn_type pick(
    input port_a_steer_pkg::fn_type hi,
    input port_a_steer_pkg::fn_type lo
  );
    pick = hi.en ? hi : lo;
  endfunction

  // latch request of one pin, driver controlled by direction
  function automatic port_a_steer_pkg::fn_type latch_fn(
    input logic dir,
    input logic val
  );
    latch_fn = '{en: 1'b1, oe: ~dir, val: val};
  endfunction

  // ==========================================================
  // combinational next state
  always_comb begin
    port_a_steer_pkg::fn_type a0;
    port_a_steer_pkg::fn_type a1;
    port_a_steer_pkg::fn_type a2;
    port_a_steer_pkg::fn_type a4;
    port_a_steer_pkg::fn_type a5;
    port_a_steer_pkg::fn_type cell_a2;
    logic [5:0]               dig_now;
    next_st = st;
    next_st.rdata = 8'h00;
    a0 = '0;
    a1 = '0;
    a2 = '0;
    a4 = '0;
    a5 = '0;
    cell_a2 = '0;
    // digital input buffer is off on analog pins
    dig_now = pin_a_in_i & ~st.ansel;

    // register writes land on the next edge
    if (bus_i.wr) begin
      case (bus_i.addr)
        `OFS_PIN_DATA, `OFS_OUTPUT_LATCH: begin
          // cpu bit ops already merged the pin levels
          next_st.latch = bus_i.wdata[5:0] & `MASK_LATCH;
        end
        `OFS_DIRECTION: begin
          next_st.dir = (bus_i.wdata[5:0] & `MASK_DIRECTION)
                        | ~`MASK_DIRECTION;
        end
        `OFS_ANALOG_SELECT: begin
          next_st.ansel = bus_i.wdata[5:0] & `MASK_ANALOG;
        end
        `OFS_STEERING: begin
          next_st.steer = bus_i.wdata & `MASK_STEERING;
        end
        default: begin
          next_st = next_st;
        end
      endcase
    end

    // reads answer one cycle later; unmapped reads give zero
    if (bus_i.rd) begin
      case (bus_i.addr)
        `OFS_PIN_DATA:      next_st.rdata = {2'b00, dig_now};
        `OFS_OUTPUT_LATCH:  next_st.rdata = {2'b00, st.latch};
        `OFS_DIRECTION:     next_st.rdata = {2'b00, st.dir};
        `OFS_ANALOG_SELECT: next_st.rdata = {2'b00, st.ansel};
        `OFS_STEERING:      next_st.rdata = st.steer;
        default:            next_st.rdata = 8'h00;
      endcase
    end

    // output priority chains; analog select is not looked at
    cell_a2 = periph_i.logic_cell;
    cell_a2.en = periph_i.logic_cell.en & ~st.steer[`POS_LC_STEER];
    a0 = pick(periph_i.prog_data,
              pick(periph_i.conv_one, latch_fn(st.dir[0], st.latch[0])));
    a1 = latch_fn(st.dir[1], st.latch[1]);
    a2 = pick(periph_i.conv_two, pick(cell_a2, pick(periph_i.comparator,
         pick(periph_i.pulse_width, latch_fn(st.dir[2], st.latch[2])))));
    a4 = pick(periph_i.clock_out,
              pick(periph_i.sosc_drive, latch_fn(st.dir[4], st.latch[4])));
    a5 = pick(periph_i.sosc_input, latch_fn(st.dir[5], st.latch[5]));
    // drivers follow the winner, analog mode or not
    next_st.pin_out = {a5.val, a4.val, 1'b0, a2.val, a1.val, a0.val};
    next_st.pin_oe = {a5.oe, a4.oe, 1'b0, a2.oe, a1.oe, a0.oe};
    next_st.dig = dig_now;

    // port c overrides only on the selected pin
    next_st.pc.ovr[0] = periph_i.numeric_osc.en & ~st.steer[`POS_OSC_STEER];
    next_st.pc.ovr[1] = periph_i.logic_cell.en & st.steer[`POS_LC_STEER];
    next_st.pc.ovr[2] = periph_i.numeric_osc.en & st.steer[`POS_OSC_STEER];
    next_st.pc.out = {periph_i.numeric_osc.val, periph_i.logic_cell.val,
                      periph_i.numeric_osc.val};
    next_st.pc.oe = next_st.pc.ovr & {periph_i.numeric_osc.oe,
                    periph_i.logic_cell.oe, periph_i.numeric_osc.oe};

    // steered peripheral inputs
    next_st.slave_sel = st.steer[`POS_SS_STEER] ?
                        pin_a_in_i[`POS_INPUT_ONLY] : pin_c_in_i[2];
    next_st.timer_gate = st.steer[`POS_TG_STEER] ?
                         pin_a_in_i[`POS_INPUT_ONLY] : dig_now[4];
  end

  // ==========================================================
  // state register, synchronous reset
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st <= RESET_STATE;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs straight from the state flops
  assign rdata_o        = st.rdata;
  assign pin_a_out_o    = st.pin_out;
  assign pin_a_oe_o     = st.pin_oe;
  assign pin_a_dig_o    = st.dig;
  assign pin_c_o        = st.pc;
  assign slave_select_o = st.slave_sel;
  assign timer_gate_o   = st.timer_gate;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  a_latch_write: assert property (
    bus_i.wr && (bus_i.addr == `OFS_OUTPUT_LATCH || bus_i.addr == `OFS_PIN_DATA)
    |=> st.latch == ($past(bus_i.wdata[5:0]) & `MASK_LATCH))
    else $error("latch not loaded by write");

  a_latch_read: assert property (
    bus_i.rd && bus_i.addr == `OFS_OUTPUT_LATCH && !bus_i.wr
    |=> rdata_o == {2'b00, $past(st.latch)})
    else $error("latch read wrong");

  a_pin_read: assert property (
    bus_i.rd && bus_i.addr == `OFS_PIN_DATA
    |=> rdata_o == {2'b00, $past(pin_a_in_i) & ~$past(st.ansel)})
    else $error("pin data read wrong");

  a_dig_buffer: assert property (
    ##1 (pin_a_dig_o & $past(st.ansel)) == 6'h00)
    else $error("digital buffer active on analog pin");

  a_input_only: assert property (
    st.dir[`POS_INPUT_ONLY] && !pin_a_oe_o[`POS_INPUT_ONLY])
    else $error("pin a3 not input only");

  a_steer_zero: assert property (
    (st.steer & ~`MASK_STEERING) == 8'h00)
    else $error("unused steering bit set");

  a_latch_drive: assert property (
    !st.dir[1] |=> pin_a_oe_o[1] && pin_a_out_o[1] == $past(st.latch[1]))
    else $error("latch not driven on output pin");

  a_prog_wins: assert property (
    periph_i.prog_data.en |=> pin_a_out_o[0] == $past(periph_i.prog_data.val)
    && pin_a_oe_o[0] == $past(periph_i.prog_data.oe))
    else $error("program data lost priority");

  a_ss_steer: assert property (
    st.steer[`POS_SS_STEER] |=> slave_select_o == $past(pin_a_in_i[3]))
    else $error("slave select steering wrong");

  a_reset_analog: assert property (
    $fell(reset_i) |-> st.ansel == `RST_ANALOG && st.dir == `RST_DIRECTION
    && st.steer == `RST_STEERING && pin_a_oe_o == 6'h00)
    else $error("reset values wrong");

  // ==========================================================
  // register bus checks
  // a write is visible in the state one edge later, never in the same cycle
  a_dir_write: assert property (
    bus_i.wr && bus_i.addr == `OFS_DIRECTION
    |=> st.dir[`POS_INPUT_ONLY] && (st.dir & `MASK_DIRECTION) == ($past(bus_i.wdata[5:0]) & `MASK_DIRECTION))
    else $error("direction write wrong");

  a_ansel_write: assert property (
    bus_i.wr && bus_i.addr == `OFS_ANALOG_SELECT |=> st.ansel == ($past(bus_i.wdata[5:0]) & `MASK_ANALOG))
    else $error("analog select write wrong");

  a_steer_write: assert property (
    bus_i.wr && bus_i.addr == `OFS_STEERING |=> st.steer == ($past(bus_i.wdata) & `MASK_STEERING))
    else $error("steering write wrong");

  a_rdata_idle: assert property (
    !bus_i.rd |=> rdata_o == 8'h00)
    else $error("read data not idle");

  a_steer_read: assert property (
    bus_i.rd && bus_i.addr == `OFS_STEERING |=> rdata_o[7:5] == 3'h0 && !rdata_o[2])
    else $error("unused steering bits read back");

  a_dir_read: assert property (
    bus_i.rd && bus_i.addr == `OFS_DIRECTION |=> rdata_o[`POS_INPUT_ONLY])
    else $error("input only direction bit reads zero");

  // ==========================================================
  // steering checks
  // a moved function must let go of its old pin, or two drivers would fight
  a_lc_c5: assert property (
    periph_i.logic_cell.en && st.steer[`POS_LC_STEER]
    |=> pin_c_o.ovr[1] && pin_c_o.out[1] == $past(periph_i.logic_cell.val))
    else $error("logic cell not on c5");

  a_lc_a2_free: assert property (
    st.steer[`POS_LC_STEER] && !periph_i.conv_two.en && periph_i.comparator.en
    |=> pin_a_out_o[2] == $past(periph_i.comparator.val) && pin_a_oe_o[2] == $past(periph_i.comparator.oe))
    else $error("moved logic cell still claims a2");

  a_osc_c6: assert property (
    periph_i.numeric_osc.en && st.steer[`POS_OSC_STEER] |=> pin_c_o.ovr[2] && !pin_c_o.ovr[0])
    else $error("oscillator output not on c6");

  a_osc_c1: assert property (
    periph_i.numeric_osc.en && !st.steer[`POS_OSC_STEER] |=> pin_c_o.ovr[0] && !pin_c_o.ovr[2])
    else $error("oscillator output not on c1");

  a_ss_c6: assert property (
    !st.steer[`POS_SS_STEER] |=> slave_select_o == $past(pin_c_in_i[2]))
    else $error("slave select not from c6");

  a_tg_a3: assert property (
    st.steer[`POS_TG_STEER] |=> timer_gate_o == $past(pin_a_in_i[3]))
    else $error("timer gate not from a3");

  a_tg_a4: assert property (
    !st.steer[`POS_TG_STEER] |=> timer_gate_o == ($past(pin_a_in_i[4]) && !$past(st.ansel[4])))
    else $error("timer gate not from a4");

  // ==========================================================
  // output priority checks
  // every pin output is registered, so a claim shows one cycle later
  a_conv_one: assert property (
    !periph_i.prog_data.en && periph_i.conv_one.en
    |=> pin_a_out_o[0] == $past(periph_i.conv_one.val) && pin_a_oe_o[0] == $past(periph_i.conv_one.oe))
    else $error("converter one lost a0");

  a_conv_two: assert property (
    periph_i.conv_two.en
    |=> pin_a_out_o[2] == $past(periph_i.conv_two.val) && pin_a_oe_o[2] == $past(periph_i.conv_two.oe))
    else $error("converter two lost a2");

  a_clock_out: assert property (
    periph_i.clock_out.en
    |=> pin_a_out_o[4] == $past(periph_i.clock_out.val) && pin_a_oe_o[4] == $past(periph_i.clock_out.oe))
    else $error("clock out lost a4");

  a_osc_input: assert property (
    periph_i.sosc_input.en
    |=> pin_a_out_o[5] == $past(periph_i.sosc_input.val) && pin_a_oe_o[5] == $past(periph_i.sosc_input.oe))
    else $error("oscillator input lost a5");

  a_analog_drive: assert property (
    st.ansel[4] && !st.dir[4] && !periph_i.clock_out.en && !periph_i.sosc_drive.en
    |=> pin_a_oe_o[4] && pin_a_out_o[4] == $past(st.latch[4]))
    else $error("analog pin stopped driving latch");

  a_dir_release: assert property (
    st.dir[1] |=> !pin_a_oe_o[1])
    else $error("driver on with direction set");

  // ==========================================================
  // per pin: digital buffer follows the pad unless the pin is analog
  for (genvar g = 0; g < 6; g++) begin : g_pin_chk
    a_dig_follow: assert property (
      @(posedge clk_i) disable iff (reset_i)
      ##1 pin_a_dig_o[g] == ($past(pin_a_in_i[g]) & ~$past(st.ansel[g])))
      else $error("digital buffer does not follow pin");
  end

  c_pin_read: cover property (bus_i.rd && bus_i.addr == `OFS_PIN_DATA ##1 rdata_o != 8'h00);
  c_steer_set: cover property (st.steer == `MASK_STEERING);
  c_prog_win: cover property (periph_i.prog_data.en && periph_i.conv_one.en);
  c_lc_moved: cover property (st.steer[`POS_LC_STEER] && periph_i.logic_cell.en);
  c_analog_drive: cover property (st.ansel[4] && !st.dir[4]);

endmodule

// ===== test/pin_partner.sv
`timescale 1ns/1ps
// ==========================================
// pads of port a and the steered port c pins
module pin_partner (
  input  wire logic [5:0]                   a_out_i,
  input  wire logic [5:0]                   a_oe_i,
  input  wire logic [5:0]                   a_ext_i,
  input  wire port_a_steer_pkg::port_c_type c_i,
  input  wire logic [2:0]                   c_ext_i,
  output logic      [5:0]                   a_lvl_o,
  output logic      [2:0]                   c_lvl_o
);
  // a released pad shows the outside level, which the bench re-rolls each step
  assign a_lvl_o = (a_oe_i & a_out_i) | (~a_oe_i & a_ext_i);
  assign c_lvl_o = (c_i.oe & c_i.out) | (~c_i.oe & c_ext_i);
endmodule

// ===== test/port_a_with_pin_steering_tb.sv
`timescale 1ns/1ps
`include "port_a_steer_cfg.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module port_a_with_pin_steering_tb;
  logic                         clk_i = 1'b0;
  logic                         reset_i = 1'b1;
  port_a_steer_pkg::bus_type    bus_i = '0;
  port_a_steer_pkg::periph_type periph_i = '0;
  port_a_steer_pkg::port_c_type pin_c_o;
  port_a_steer_pkg::fn_type     lc;
  logic [7:0]                   rdata_o, st;
  logic [5:0]                   pin_a_in_i, pin_a_out_o, pin_a_oe_o, pin_a_dig_o, ext_a = 6'h00;
  logic [5:0]                   lat, dr, an, o, e, lvl;
  logic [2:0]                   pin_c_in_i, ext_c = 3'h0, ce, cv, cl;
  logic [1:0]                   b0, b2, b4, b5;
  logic [31:0]                  r;
  logic                         slave_select_o, timer_gate_o;
  int                           error_cnt = 0, n_compared = 0, seed = 66;

  port_a_with_pin_steering i_dut (.clk_i(clk_i), .reset_i(reset_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .pin_a_in_i(pin_a_in_i), .pin_a_out_o(pin_a_out_o), .pin_a_oe_o(pin_a_oe_o), .pin_a_dig_o(pin_a_dig_o),
    .pin_c_in_i(pin_c_in_i), .pin_c_o(pin_c_o), .periph_i(periph_i), .slave_select_o(slave_select_o),
    .timer_gate_o(timer_gate_o));
  pin_partner i_pads (.a_out_i(pin_a_out_o), .a_oe_i(pin_a_oe_o), .a_ext_i(ext_a), .c_i(pin_c_o),
    .c_ext_i(ext_c), .a_lvl_o(pin_a_in_i), .c_lvl_o(pin_c_in_i));

  initial begin
    forever #50 clk_i = ~clk_i;
  end

  // ==========================================
  // bus tasks; each starts and ends just after a rising edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus_i.addr <= a;
    bus_i.wdata <= d;
    bus_i.wr <= 1'b1;
    @(posedge clk_i);
    bus_i.wr <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] x);
    bus_i.addr <= a;
    bus_i.rd <= 1'b1;
    @(posedge clk_i);
    bus_i.rd <= 1'b0;
    #1 `CHK(rdata_o, x)
    @(posedge clk_i);
  endtask

  // winner of two claims: {value, output enable}
  function automatic logic [1:0] sel(input port_a_steer_pkg::fn_type f, input logic [1:0] d);
    return f.en ? {f.val, f.oe} : d;
  endfunction

  task automatic summarize;
    $display("compared %0d, wrong %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // a hang costs at most a few thousand cycles
  initial begin
    #600000;
    error_cnt++;
    summarize();
  end

  // ==========================================
  // main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    rd(`OFS_OUTPUT_LATCH, 8'h00);
    rd(`OFS_DIRECTION, 8'h3F);
    rd(`OFS_ANALOG_SELECT, 8'h17);
    rd(`OFS_STEERING, 8'h00);
    $display("test reset values done");
    wr(`OFS_STEERING, 8'hFF);
    rd(`OFS_STEERING, 8'h1B);
    wr(`OFS_DIRECTION, 8'h00);
    rd(`OFS_DIRECTION, 8'h08);
    wr(3'h5, 8'hFF);
    rd(3'h5, 8'h00);
    $display("test register masks done");
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      lat = r[5:0] & 6'h37;
      dr = r[11:6] | 6'h08;
      an = r[17:12] & 6'h17;
      st = r[25:18] & 8'h1B;
      wr(i[0] ? `OFS_PIN_DATA : `OFS_OUTPUT_LATCH, {2'b00, r[5:0]});
      wr(`OFS_DIRECTION, {2'b00, r[11:6]});
      wr(`OFS_ANALOG_SELECT, {2'b00, r[17:12]});
      wr(`OFS_STEERING, r[25:18]);
      r = $random(seed);
      periph_i <= (i == 0) ? '1 : (i == 1) ? '0 : r[29:0];
      r = $random(seed);
      ext_a <= r[5:0];
      ext_c <= r[8:6];
      repeat (3) @(posedge clk_i);
      #1;
      lc = periph_i.logic_cell;
      lc.en = lc.en & ~st[1];
      b0 = sel(periph_i.prog_data, sel(periph_i.conv_one, {lat[0], ~dr[0]}));
      b2 = sel(periph_i.conv_two, sel(lc, sel(periph_i.comparator, sel(periph_i.pulse_width, {lat[2], ~dr[2]}))));
      b4 = sel(periph_i.clock_out, sel(periph_i.sosc_drive, {lat[4], ~dr[4]}));
      b5 = sel(periph_i.sosc_input, {lat[5], ~dr[5]});
      o = {b5[1], b4[1], 1'b0, b2[1], lat[1], b0[1]};
      e = {b5[0], b4[0], 1'b0, b2[0], ~dr[1], b0[0]};
      lvl = (e & o) | (~e & ext_a);
      ce = {st[0], st[1], ~st[0]} & {periph_i.numeric_osc.en, periph_i.logic_cell.en, periph_i.numeric_osc.en};
      cv = {periph_i.numeric_osc.val, periph_i.logic_cell.val, periph_i.numeric_osc.val};
      cl = {periph_i.numeric_osc.oe, periph_i.logic_cell.oe, periph_i.numeric_osc.oe} & ce;
      `CHK(pin_a_oe_o, e)
      `CHK(pin_a_out_o & e, o & e)
      `CHK(pin_a_dig_o, lvl & ~an)
      `CHK(pin_c_o.ovr, ce)
      `CHK(pin_c_o.oe, cl)
      `CHK(pin_c_o.out & cl, cv & cl)
      `CHK(slave_select_o, st[4] ? lvl[3] : ((cl & cv) | (~cl & ext_c)) >> 2)
      `CHK(timer_gate_o, st[3] ? lvl[3] : lvl[4] & ~an[4])
      @(posedge clk_i);
      rd(`OFS_PIN_DATA, {2'b00, lvl & ~an});
      rd(`OFS_OUTPUT_LATCH, {2'b00, lat});
      rd(`OFS_DIRECTION, {2'b00, dr});
    end
    $display("test random pin traffic done");
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    rd(`OFS_ANALOG_SELECT, 8'h17);
    rd(`OFS_DIRECTION, 8'h3F);
    rd(`OFS_STEERING, 8'h00);
    rd(`OFS_OUTPUT_LATCH, 8'h00);
    $display("test second reset done");
    summarize();
  end
endmodule
